// ---- verilog/aspg_pkg.sv ----
// Operation
// R1 - read-only four-bit revision in control bits 7:4
// R2 - unlock bit admits writes to 0x3D-0x3F
// R3 - writing zero to hold bit powers down
// R4 - bus start condition wakes the powered-down device
// R5 - host sets wake-select before clearing hold bit
// R6 - hold bit reads one after power-on
// R7 - status bit 6 shows supply brown-out
// R8 - status bit 5 shows power-up sequence done
// R9 - status bit 4 shows headphone amp power
// R10 - status bit 3 shows preamp power
// R11 - status bit 1 shows mic pump power
// R12 - status bit 0 shows mic supply power
// R13 - six-bit gains: mute, 0 dB, 0.5 dB steps
// R14 - select bit chooses alternative or primary gains
// R15 - software never writes right test bit 7
// R16 - alternative pair used after primary programmed
// R17 - unused bits read zero, ignore writes
package aspg_pkg;

    // register offsets
    localparam logic [7:0] RIGHT_ALT_OFFSET = 8'h10;
    localparam logic [7:0] LEFT_ALT_OFFSET = 8'h11;
    localparam logic [7:0] SYSTEM_CONTROL_OFFSET = 8'h20;
    localparam logic [7:0] POWER_STATUS_OFFSET = 8'h21;
    localparam logic [7:0] EVAL_FIRST_OFFSET = 8'h3D;
    localparam logic [7:0] EVAL_LAST_OFFSET = 8'h3F;

    // field positions
    localparam int REVISION_LSB = 4;
    localparam int UNLOCK_BIT = 3;
    localparam int HOLD_BIT = 0;
    localparam int SELECT_BIT = 7;
    localparam int TEST_BIT = 7;
    localparam int GAIN_BITS = 6;
    localparam int STATUS_BITS = 6;

    // status input order, packed into register bits 0,1,3,4,5,6
    localparam int ST_SUPPLY = 0;
    localparam int ST_PUMP = 1;
    localparam int ST_PREAMP = 2;
    localparam int ST_HEADPHONE = 3;
    localparam int ST_POWERUP = 4;
    localparam int ST_BROWNOUT = 5;

    // reset values
    localparam logic [7:0] RIGHT_ALT_RESET = 8'h80;
    localparam logic [7:0] LEFT_ALT_RESET = 8'h00;
    localparam logic [5:0] GAIN_MUTE = 6'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // startup sequencer states
    typedef enum logic [1:0] {
        st_load,
        st_run,
        st_down
    } aspg_state_e;

endpackage

// ---- verilog/aspg_link_if.sv ----
`timescale 1ns/1ps
// request and answer between the link domain and the register core
interface aspg_link_if;
    logic req_toggle;
    logic req_write;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic ack_toggle;
    logic [7:0] ack_data;

    modport link (
        output req_toggle,
        output req_write,
        output req_addr,
        output req_wdata,
        input ack_toggle,
        input ack_data
    );

    modport core (
        input req_toggle,
        input req_write,
        input req_addr,
        input req_wdata,
        output ack_toggle,
        output ack_data
    );
endinterface

// ---- verilog/aspg_link_port.sv ----
`timescale 1ns/1ps
// link-clock side: holds one request until the core answers
module aspg_link_port
    import aspg_pkg::*;
(
    input wire logic link_clock,
    input wire logic reset,
    input wire logic link_write_strobe,
    input wire logic link_read_strobe,
    input wire logic [7:0] link_address,
    input wire logic [7:0] link_write_data,
    output logic link_busy,
    output logic link_read_valid,
    output logic [7:0] link_read_data,
    aspg_link_if.link port
);

    typedef struct packed {
        logic req_toggle;
        logic req_write;
        logic [7:0] req_addr;
        logic [7:0] req_wdata;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic [7:0] read_data;
        logic read_valid;
    } aspg_link_s;

    aspg_link_s state_reg;
    aspg_link_s state_next;

    // accept one request, wait for the toggled answer
    always_comb begin
        state_next = state_reg;
        state_next.ack_s1 = port.ack_toggle;
        state_next.ack_s2 = state_reg.ack_s1;
        state_next.read_valid = 1'b0;
        if (state_reg.ack_s2 != state_reg.ack_seen) begin
            state_next.ack_seen = state_reg.ack_s2;
            state_next.busy = 1'b0;
            if (!state_reg.req_write) begin
                // answer data is held still by the core until next request
                state_next.read_data = port.ack_data;
                state_next.read_valid = 1'b1;
            end
        end else if (!state_reg.busy &&
                     (link_write_strobe || link_read_strobe)) begin
            state_next.req_write = link_write_strobe;
            state_next.req_addr = link_address;
            state_next.req_wdata = link_write_data;
            state_next.req_toggle = ~state_reg.req_toggle;
            state_next.busy = 1'b1;
        end
    end

    // link clock may stop between frames; state simply holds
    always_ff @(posedge link_clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign port.req_toggle = state_reg.req_toggle;
    assign port.req_write = state_reg.req_write;
    assign port.req_addr = state_reg.req_addr;
    assign port.req_wdata = state_reg.req_wdata;
    assign link_busy = state_reg.busy;
    assign link_read_valid = state_reg.read_valid;
    assign link_read_data = state_reg.read_data;

endmodule

// ---- verilog/aspg_core.sv ----
`timescale 1ns/1ps
// system control, power status and alternative gain registers
module aspg_core
    import aspg_pkg::*;
#(
    // arbitrary revision value, not tied to any real part
    parameter logic [3:0] DESIGN_REVISION = 4'h2,
    parameter int GAIN_WIDTH = 6
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // link side register port
    input wire logic link_clock,
    input wire logic link_write_strobe,
    input wire logic link_read_strobe,
    input wire logic [7:0] link_address,
    input wire logic [7:0] link_write_data,
    output logic link_busy,
    output logic link_read_valid,
    output logic [7:0] link_read_data,
    // serial bus pins watched for the wake-up start condition
    input wire logic bus_data_pin,
    input wire logic bus_clock_pin,
    // wake-select mode bit held in a neighbouring register
    input wire logic serial_wake_select,
    // analog status inputs
    input wire logic supply_brownout_flag,
    input wire logic powerup_done_flag,
    input wire logic headphone_amp_powered,
    input wire logic preamp_powered,
    input wire logic mic_pump_powered,
    input wire logic mic_supply_powered,
    // primary gains from the primary gain registers
    input wire logic [5:0] right_mic_gain_primary,
    input wire logic [5:0] left_mic_gain_primary,
    // results
    output logic powered_down,
    output logic [5:0] right_gain_active,
    output logic [5:0] left_gain_active,
    output logic eval_write_pulse,
    output logic [7:0] eval_write_address,
    output logic [7:0] eval_write_data
);

    // the gain layout is fixed by the six-bit code table
    if (GAIN_WIDTH != GAIN_BITS) begin : gain_width_check
        $error("GAIN_WIDTH must be 6");
    end

    typedef struct packed {
        // request handshake from the link domain
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_toggle;
        logic [7:0] ack_data;
        // pin and status synchronisers
        logic [STATUS_BITS-1:0] status_s1;
        logic [STATUS_BITS-1:0] status_s2;
        logic sda_s1;
        logic sda_s2;
        logic sda_prev;
        logic scl_s1;
        logic scl_s2;
        // registers
        logic test_bit;
        logic [5:0] right_alt_field;
        logic second_gain_set_select;
        logic [5:0] left_alt_field;
        logic evaluation_write_unlock;
        logic power_hold_bit;
        // sequencer and outputs
        aspg_state_e seq;
        logic powered_down;
        logic [5:0] right_active;
        logic [5:0] left_active;
        logic eval_pulse;
        logic [7:0] eval_addr;
        logic [7:0] eval_data;
    } aspg_core_s;

    aspg_core_s state_reg;
    aspg_core_s state_next;

    aspg_link_if link_bus ();

    // register port running on the link clock
    aspg_link_port link_side (
        .link_clock(link_clock),
        .reset(reset),
        .link_write_strobe(link_write_strobe),
        .link_read_strobe(link_read_strobe),
        .link_address(link_address),
        .link_write_data(link_write_data),
        .link_busy(link_busy),
        .link_read_valid(link_read_valid),
        .link_read_data(link_read_data),
        .port(link_bus.link)
    );

    logic [STATUS_BITS-1:0] status_raw;

    // status inputs gathered into one vector for synchronising
    always_comb begin
        status_raw = '0;
        status_raw[ST_SUPPLY] = mic_supply_powered;
        status_raw[ST_PUMP] = mic_pump_powered;
        status_raw[ST_PREAMP] = preamp_powered;
        status_raw[ST_HEADPHONE] = headphone_amp_powered;
        status_raw[ST_POWERUP] = powerup_done_flag;
        status_raw[ST_BROWNOUT] = supply_brownout_flag;
    end

    // true for the evaluation range 0x3D-0x3F, unlocked or not
    function automatic logic is_eval_offset(input logic [7:0] addr);
        return (addr >= EVAL_FIRST_OFFSET) && (addr <= EVAL_LAST_OFFSET);
    endfunction

    // read value of each mapped offset; unused bits read zero
    function automatic logic [7:0] read_value(
        input logic [7:0] addr,
        input aspg_core_s s
    );
        logic [7:0] value;
        value = UNMAPPED_READ;
        case (addr)
            RIGHT_ALT_OFFSET: begin
                value[TEST_BIT] = s.test_bit; // R15
                value[GAIN_BITS-1:0] = s.right_alt_field; // R13
            end
            LEFT_ALT_OFFSET: begin
                value[SELECT_BIT] = s.second_gain_set_select;
                value[GAIN_BITS-1:0] = s.left_alt_field; // R13
            end
            SYSTEM_CONTROL_OFFSET: begin
                value[7:REVISION_LSB] = DESIGN_REVISION; // R1
                value[UNLOCK_BIT] = s.evaluation_write_unlock;
                value[HOLD_BIT] = s.power_hold_bit;
            end
            POWER_STATUS_OFFSET: begin
                value[6] = s.status_s2[ST_BROWNOUT]; // R7
                value[5] = s.status_s2[ST_POWERUP]; // R8
                value[4] = s.status_s2[ST_HEADPHONE]; // R9
                value[3] = s.status_s2[ST_PREAMP]; // R10
                value[1] = s.status_s2[ST_PUMP]; // R11
                value[0] = s.status_s2[ST_SUPPLY]; // R12
            end
            default: begin
                value = UNMAPPED_READ; // R17
            end
        endcase
        return value;
    endfunction

    logic new_request;
    logic start_seen;
    logic hold_cleared;

    // request edge and start condition (data falls while clock high)
    always_comb begin
        new_request = state_reg.req_s2 != state_reg.req_seen;
        start_seen = state_reg.sda_prev && !state_reg.sda_s2 &&
                     state_reg.scl_s2; // R4
    end

    // next state of the whole core
    always_comb begin
        state_next = state_reg;
        hold_cleared = 1'b0;
        state_next.eval_pulse = 1'b0;

        // synchronisers: stage one is read only by stage two
        state_next.req_s1 = link_bus.req_toggle;
        state_next.req_s2 = state_reg.req_s1;
        state_next.status_s1 = status_raw;
        state_next.status_s2 = state_reg.status_s1;
        state_next.sda_s1 = bus_data_pin;
        state_next.sda_s2 = state_reg.sda_s1;
        state_next.sda_prev = state_reg.sda_s2;
        state_next.scl_s1 = bus_clock_pin;
        state_next.scl_s2 = state_reg.scl_s1;

        // serve one link request, answer by toggling back
        if (new_request) begin
            state_next.req_seen = state_reg.req_s2;
            state_next.ack_toggle = ~state_reg.ack_toggle;
            if (link_bus.req_write) begin
                state_next.ack_data = state_reg.ack_data;
                case (link_bus.req_addr)
                    RIGHT_ALT_OFFSET: begin
                        // bit 7 stays read-only, bit 6 unused
                        state_next.right_alt_field =
                            link_bus.req_wdata[GAIN_BITS-1:0]; // R13
                    end
                    LEFT_ALT_OFFSET: begin
                        state_next.second_gain_set_select =
                            link_bus.req_wdata[SELECT_BIT];
                        state_next.left_alt_field =
                            link_bus.req_wdata[GAIN_BITS-1:0]; // R13
                    end
                    SYSTEM_CONTROL_OFFSET: begin
                        // revision bits and bits 2:1 ignore writes
                        state_next.evaluation_write_unlock =
                            link_bus.req_wdata[UNLOCK_BIT];
                        if (link_bus.req_wdata[HOLD_BIT]) begin
                            state_next.power_hold_bit = 1'b1;
                        end else if (serial_wake_select) begin // R5
                            state_next.power_hold_bit = 1'b0; // R3
                            hold_cleared = 1'b1;
                        end
                    end
                    default: begin
                        // evaluation range passes out only when unlocked
                        if (is_eval_offset(link_bus.req_addr) &&
                            state_reg.evaluation_write_unlock) begin // R2
                            state_next.eval_pulse = 1'b1;
                            state_next.eval_addr = link_bus.req_addr;
                            state_next.eval_data = link_bus.req_wdata;
                        end
                    end
                endcase
            end else begin
                state_next.ack_data =
                    read_value(link_bus.req_addr, state_reg);
            end
        end

        // startup sequencer: load gains, run, sleep until a start
        case (state_reg.seq)
            st_load: begin
                if (state_reg.second_gain_set_select) begin // R14
                    state_next.right_active = state_reg.right_alt_field;
                    state_next.left_active = state_reg.left_alt_field;
                end else begin
                    state_next.right_active = right_mic_gain_primary;
                    state_next.left_active = left_mic_gain_primary;
                end
                state_next.powered_down = 1'b0;
                state_next.seq = st_run;
            end
            st_run: begin
                // a clear that landed during the load cycle still counts
                if (hold_cleared || !state_reg.power_hold_bit) begin
                    state_next.powered_down = 1'b1; // R3
                    state_next.seq = st_down;
                end
            end
            st_down: begin
                if (start_seen) begin // R4
                    state_next.power_hold_bit = 1'b1;
                    state_next.seq = st_load;
                end
            end
            default: begin
                state_next.seq = st_load;
            end
        endcase
    end

    // all core state; power-on sets the hold bit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.test_bit <= RIGHT_ALT_RESET[TEST_BIT]; // R15
            state_reg.right_alt_field <= RIGHT_ALT_RESET[5:0];
            state_reg.second_gain_set_select <= LEFT_ALT_RESET[SELECT_BIT];
            state_reg.left_alt_field <= LEFT_ALT_RESET[5:0];
            state_reg.power_hold_bit <= 1'b1; // R6
            state_reg.sda_s1 <= 1'b1;
            state_reg.sda_s2 <= 1'b1;
            state_reg.sda_prev <= 1'b1;
            state_reg.right_active <= GAIN_MUTE;
            state_reg.left_active <= GAIN_MUTE;
            state_reg.seq <= st_load;
        end else if (clock_enable) begin
            state_reg <= state_next;
        end
    end

    // answer back to the link domain
    assign link_bus.ack_toggle = state_reg.ack_toggle;
    assign link_bus.ack_data = state_reg.ack_data;

    // outputs straight from the state register
    assign powered_down = state_reg.powered_down;
    assign right_gain_active = state_reg.right_active;
    assign left_gain_active = state_reg.left_active;
    assign eval_write_pulse = state_reg.eval_pulse;
    assign eval_write_address = state_reg.eval_addr;
    assign eval_write_data = state_reg.eval_data;

endmodule

// ---- sim/aspg_assertions.sv ----
`timescale 1ns/1ps
// port-level checks of the link handshake, wake-up and evaluation pulses
module aspg_assertions (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic link_clock,
    input wire logic link_write_strobe,
    input wire logic link_read_strobe,
    input wire logic link_busy,
    input wire logic link_read_valid,
    input wire logic [7:0] link_read_data,
    input wire logic bus_data_pin,
    input wire logic bus_clock_pin,
    input wire logic serial_wake_select,
    input wire logic powered_down,
    input wire logic eval_write_pulse,
    input wire logic [7:0] eval_write_address
);
    a_take_sets_busy: assert property (
        @(posedge link_clock) disable iff (reset)
        (link_write_strobe || link_read_strobe) && !link_busy |=> link_busy)
        else $error("request not taken");
    a_answer_in_time: assert property (
        @(posedge link_clock) disable iff (reset)
        $rose(link_busy) |-> ##[1:20] !link_busy)
        else $error("answer too late");
    a_valid_ends_busy: assert property (
        @(posedge link_clock) disable iff (reset)
        link_read_valid |-> $fell(link_busy))
        else $error("read answer outside busy fall");
    a_valid_one_cycle: assert property (
        @(posedge link_clock) disable iff (reset)
        link_read_valid |=> !link_read_valid)
        else $error("read answer longer than one cycle");
    a_read_data_holds: assert property (
        @(posedge link_clock) disable iff (reset)
        !link_read_valid |-> $stable(link_read_data))
        else $error("read data moved without answer");
    a_eval_in_range: assert property (
        @(posedge clock) disable iff (reset)
        eval_write_pulse |-> eval_write_address >= 8'h3D
            && eval_write_address <= 8'h3F)
        else $error("evaluation write outside its range");
    a_eval_single_pulse: assert property (
        @(posedge clock) disable iff (reset)
        eval_write_pulse |=> !eval_write_pulse)
        else $error("evaluation pulse too long");
    a_wake_on_start: assert property (
        @(posedge clock) disable iff (reset)
        powered_down && clock_enable && bus_clock_pin && $fell(bus_data_pin)
        |-> ##[1:12] !powered_down)
        else $error("no wake after start condition");
    a_down_needs_select: assert property (
        @(posedge clock) disable iff (reset)
        $rose(powered_down) |-> $past(serial_wake_select, 2))
        else $error("power-down without wake select");
endmodule

bind aspg_core aspg_assertions chk_i (.*);

// ---- sim/aspg_host.sv ----
`timescale 1ns/1ps
// host side: link clock runs only during a request or while reset is applied; bus pins pulled up
module aspg_host (
    output logic link_clock,
    output logic wr_s,
    output logic rd_s,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic busy,
    input wire logic valid,
    input wire logic [7:0] rdata,
    output logic sda,
    output logic scl
);
    // idle levels: clock stopped low, pins released high
    initial begin
        link_clock = 0;
        wr_s = 0;
        rd_s = 0;
        addr = 8'h00;
        wdata = 8'h00;
        sda = 1;
        scl = 1;
    end

    // free link cycles, used while reset is applied
    task automatic pulse(input int n);
        repeat (n) begin
            #24 link_clock = 1;
            #24 link_clock = 0;
        end
    endtask

    // one request held to its taking edge, then waits for busy to drop
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        int n;
        q = 8'hXX;
        wr_s = w;
        rd_s = !w;
        addr = a;
        wdata = d;
        #24 link_clock = 1;
        #1 wr_s = 0;
        rd_s = 0;
        addr = ~a; // released lines show no stale value
        wdata = ~d;
        #23 link_clock = 0;
        n = 0;
        do begin
            #24 link_clock = 1;
            #1 if (valid === 1'b1) q = rdata;
            #23 link_clock = 0;
            n++;
        end while (busy !== 1'b0 && n < 40);
    endtask

    // start condition: data falls while clock high
    task automatic start_cond;
        sda = 0;
        #200 scl = 0;
        #200 sda = 1;
        #200 scl = 1;
    endtask
endmodule

// ---- sim/anc_system_power_gain_registers_tb.sv ----
`timescale 1ns/1ps
module anc_system_power_gain_registers_tb;
    import aspg_pkg::*;
    logic clock = 0, reset = 1, clock_enable = 1, wake_sel = 0;
    logic [5:0] st = 6'h00;
    logic link_clock, wr_s, rd_s, busy, valid, sda, scl, pd, ev_p;
    logic [7:0] addr, wdata, rdata, ev_a, ev_d, q, cap_a, cap_d;
    logic [5:0] rg, lg;
    int miscompares = 0, n_compared = 0, cycles = 0, n_ev = 0, n;
    int bp[6] = '{0, 1, 3, 4, 5, 6};

    always #20 clock = ~clock;

    aspg_core dut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
        .link_clock(link_clock), .link_write_strobe(wr_s),
        .link_read_strobe(rd_s), .link_address(addr),
        .link_write_data(wdata), .link_busy(busy), .link_read_valid(valid),
        .link_read_data(rdata), .bus_data_pin(sda), .bus_clock_pin(scl),
        .serial_wake_select(wake_sel),
        .supply_brownout_flag(st[ST_BROWNOUT]),
        .powerup_done_flag(st[ST_POWERUP]),
        .headphone_amp_powered(st[ST_HEADPHONE]),
        .preamp_powered(st[ST_PREAMP]), .mic_pump_powered(st[ST_PUMP]),
        .mic_supply_powered(st[ST_SUPPLY]),
        .right_mic_gain_primary(6'h15), .left_mic_gain_primary(6'h2A),
        .powered_down(pd), .right_gain_active(rg), .left_gain_active(lg),
        .eval_write_pulse(ev_p), .eval_write_address(ev_a),
        .eval_write_data(ev_d));

    aspg_host host (.link_clock(link_clock), .wr_s(wr_s), .rd_s(rd_s),
        .addr(addr), .wdata(wdata), .busy(busy), .valid(valid),
        .rdata(rdata), .sda(sda), .scl(scl));

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // evaluation pulse capture and run timeout
    always @(posedge clock) begin
        if (ev_p === 1'b1) begin
            n_ev++;
            cap_a = ev_a;
            cap_d = ev_d;
        end
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            wrap_up;
        end
    end

    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, exp);
        host.xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, d);
        host.xfer(1'b1, a, d, q);
    endtask

    task automatic wait_clk(input int k);
        repeat (k) @(posedge clock);
    endtask

    // main sequence
    initial begin
        fork
            wait_clk(20);
            host.pulse(4);
        join
        reset <= 0;
        wait_clk(3);
        chk({2'b00, rg}, 8'h15);
        chk({2'b00, lg}, 8'h2A);
        rd(8'h20, 8'h21);
        rd(8'h10, 8'h80);
        rd(8'h11, 8'h00);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h29);
        for (int a = 8'h3D; a <= 8'h3F; a++) begin
            wr(a[7:0], a[7:0] ^ 8'h5A);
            chk(cap_a, a[7:0]);
            chk(cap_d, a[7:0] ^ 8'h5A);
        end
        wr(8'h20, 8'h01);
        wr(8'h3E, 8'h77);
        chk(n_ev[7:0], 8'h03);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'hBF);
        wr(8'h11, 8'hC1);
        rd(8'h11, 8'h81);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock) st <= 6'h01 << i;
            wait_clk(4);
            rd(8'h21, 8'h01 << bp[i]);
        end
        @(posedge clock) st <= 6'h00;
        wr(8'h20, 8'h00);
        wait_clk(4);
        chk({7'h00, pd}, 8'h00);
        rd(8'h20, 8'h21);
        @(posedge clock) wake_sel <= 1;
        wr(8'h20, 8'h00);
        wait_clk(4);
        chk({7'h00, pd}, 8'h01);
        rd(8'h20, 8'h20);
        // a start while the core is frozen must not wake it
        @(posedge clock) clock_enable <= 0;
        wait_clk(2);
        host.start_cond;
        @(posedge clock) clock_enable <= 1;
        wait_clk(4);
        chk({7'h00, pd}, 8'h01);
        host.start_cond;
        n = 0;
        while (pd !== 1'b0 && n < 20) begin
            @(posedge clock) n++;
        end
        chk({7'h00, pd}, 8'h00);
        wait_clk(2);
        chk({2'b00, rg}, 8'h3F);
        chk({2'b00, lg}, 8'h01);
        rd(8'h20, 8'h21);
        wrap_up;
    end
endmodule
